// file: hdl/dpz_seq.sv
// dpz_seq: device-side power-down entry/exit and calibration sequencer
// assumes: command pins come from another clock domain and are synced here
// Operation
// - cke sampled low with nop or deselect enters low_power_state
// - cke sampled high with nop or deselect leaves low_power_state
// - long calibration does initial calibration, may also come anytime (code accepts it only in idle with cke high)
// - long calibration runs engine then applies codes to drivers
// - first long calibration after reset gets the tZQinit window
// - later long calibrations get the tZQoper window
// - short calibration updates within the tZQCS window
// - short calibration corrects at least one step within 64 nCK
// - calibration current path turns off once calibration completes
// - no recalibration on self-refresh exit without explicit command
// - all data outputs are high impedance during calibration
`timescale 1ns/1ps
module dpz_seq #(
  parameter int CODE_W = 6
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              ckeIn,
  input  wire logic              csN,
  input  wire logic              rasN,
  input  wire logic              casN,
  input  wire logic              weN,
  input  wire logic              addrLong,
  input  wire logic              selfRefreshExit,
  input  wire logic [CODE_W-1:0] calTarget,
  output logic                   lowPower,
  output logic                   calBusy,
  output logic                   calCurrentOn,
  output logic                   dqOutEnN,
  output logic [CODE_W-1:0]      driverCode
);
  // -------------------------------------------------
  // input synchronisers
  // -------------------------------------------------
  logic [5:0] syncA;
  logic [5:0] syncB;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 6'h3F;
      syncB <= 6'h3F;
    end else begin
      syncA <= {ckeIn, csN, rasN, casN, weN, addrLong};
      syncB <= syncA;
    end
  end

  logic       cke;
  logic [3:0] cmd;
  logic       longSel;
  logic       isNop;
  assign cke     = syncB[5];
  assign cmd     = syncB[4:1];
  assign longSel = syncB[0];
  // deselect is cs high whatever the other pins say
  assign isNop   = cmd[3] | (cmd == dpz_pkg::CMD_NOP);

  // -------------------------------------------------
  // sequencer state
  // -------------------------------------------------
  dpz_pkg::dpz_state_t state;
  dpz_pkg::dpz_state_t next_state;
  logic              zqDone;
  logic              next_zqDone;
  logic              startCal;
  logic [9:0]        calWindow;
  logic              engBusy;
  logic [CODE_W-1:0] engCode;
  logic [CODE_W-1:0] next_driverCode;
  logic              engBusyQ;

  always_comb begin
    next_state      = state;
    next_zqDone     = zqDone;
    startCal        = 1'b0;
    calWindow       = dpz_pkg::CNT_ZERO;
    next_driverCode = driverCode;
    case (state)
      dpz_pkg::DPZ_IDLE: begin
        if (!cke && isNop) begin
          next_state = dpz_pkg::DPZ_LOWPWR;
        end else if (cke && cmd == dpz_pkg::CMD_ZQ) begin
          // self-refresh exit alone never lands here
          startCal   = 1'b1;
          next_state = dpz_pkg::DPZ_CAL;
          if (!longSel) calWindow = 10'(dpz_pkg::ZQCS_NCK);
          else if (!zqDone) calWindow = 10'(dpz_pkg::ZQINIT_NCK);
          else calWindow = 10'(dpz_pkg::ZQOPER_NCK);
          if (longSel) next_zqDone = 1'b1;
        end
      end
      dpz_pkg::DPZ_LOWPWR: begin
        if (cke && isNop) next_state = dpz_pkg::DPZ_IDLE;
      end
      dpz_pkg::DPZ_CAL: begin
        // codes reach the drivers only once the engine settles
        if (engBusyQ && !engBusy) begin
          next_driverCode = engCode;
          next_state      = dpz_pkg::DPZ_IDLE;
        end
      end
      default: next_state = dpz_pkg::DPZ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= dpz_pkg::DPZ_IDLE;
      zqDone     <= 1'b0;
      driverCode <= '0;
      engBusyQ   <= 1'b0;
    end else begin
      state      <= next_state;
      zqDone     <= next_zqDone;
      driverCode <= next_driverCode;
      engBusyQ   <= engBusy;
    end
  end

  // -------------------------------------------------
  // registered outputs
  // -------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowPower     <= 1'b0;
      calBusy      <= 1'b0;
      calCurrentOn <= 1'b0;
      dqOutEnN     <= 1'b1;
    end else begin
      lowPower     <= (next_state == dpz_pkg::DPZ_LOWPWR);
      calBusy      <= (next_state == dpz_pkg::DPZ_CAL);
      calCurrentOn <= (next_state == dpz_pkg::DPZ_CAL);
      dqOutEnN     <= 1'b1;
    end
  end

  dpz_cal_engine #(
    .CODE_W (CODE_W)
  ) u_engine (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (startCal),
    .window  (calWindow),
    .target  (calTarget),
    .busy    (engBusy),
    .code    (engCode)
  );

  logic unusedSr;
  assign unusedSr = selfRefreshExit;
endmodule

// file: hdl/dpz_pkg.sv
// dpz_pkg: constants for the power-down and calibration sequencer
// assumes: 100 MHz sys_clk, memory command bus sampled on the same clock
package dpz_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // command encodings {csN, rasN, casN, weN}
  localparam logic [3:0] CMD_NOP   = 4'h7;
  localparam logic [3:0] CMD_ZQ    = 4'h6;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam int ZQ_LONG_BIT       = 10;
  // calibration windows in clock cycles of the memory clock
  localparam int ZQINIT_NCK        = 512;
  localparam int ZQOPER_NCK        = 256;
  localparam int ZQCS_NCK          = 64;
  // short calibration needs at most this many nCK for its correction step
  localparam int ZQCS_CORR_NCK     = 64;
  localparam logic [9:0] CNT_ZERO  = 10'h000;
  typedef enum logic [1:0] {DPZ_IDLE, DPZ_LOWPWR, DPZ_CAL} dpz_state_t;
endpackage

// file: hdl/dpz_cal_engine.sv
// dpz_cal_engine: calibration window counter and impedance code stepper
// assumes: start is a one-cycle pulse from the sequencer on the same clock
`timescale 1ns/1ps
module dpz_cal_engine #(
  parameter int CODE_W = 6
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire logic [9:0]        window,
  input  wire logic [CODE_W-1:0] target,
  output logic                   busy,
  output logic [CODE_W-1:0]      code
);
  initial begin
    if (CODE_W < 2) $error("CODE_W too small");
  end

  logic [9:0]        count;
  logic [9:0]        next_count;
  logic [CODE_W-1:0] next_code;
  logic              next_busy;

  // -------------------------------------------------
  // engine: step the working code one lsb per cycle
  // -------------------------------------------------
  always_comb begin
    next_count = count;
    next_code  = code;
    next_busy  = busy;
    if (start) begin
      next_count = window;
      next_busy  = 1'b1;
    end else if (busy) begin
      if (code < target) next_code = code + 1'b1;
      else if (code > target) next_code = code - 1'b1;
      next_count = count - 10'h001;
      if (count == 10'h001) next_busy = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 10'h000;
      code  <= '0;
      busy  <= 1'b0;
    end else begin
      count <= next_count;
      code  <= next_code;
      busy  <= next_busy;
    end
  end
endmodule

// file: tb/dpz_seq_asserts.sv
// dpz_seq_asserts: port checks for the sequencer
// assumes: bound onto dpz_seq, one clock, windows from dpz_pkg
`timescale 1ns/1ps
module dpz_seq_asserts #(
  parameter int CODE_W = 6
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              ckeIn,
  input wire logic              csN,
  input wire logic              rasN,
  input wire logic              casN,
  input wire logic              weN,
  input wire logic              addrLong,
  input wire logic              selfRefreshExit,
  input wire logic [CODE_W-1:0] calTarget,
  input wire logic              lowPower,
  input wire logic              calBusy,
  input wire logic              calCurrentOn,
  input wire logic              dqOutEnN,
  input wire logic [CODE_W-1:0] driverCode
);
  logic [9:0] busyCnt;
  logic [9:0] expWin;
  logic       longSeen;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // window is reckoned from the command seen 3 edges before busy rose
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busyCnt <= 10'h000;
      expWin <= 10'h000;
      longSeen <= 1'b0;
    end else begin
      busyCnt <= calBusy ? busyCnt + 10'h001 : 10'h000;
      if ($rose(calBusy)) begin
        expWin <= !$past(addrLong, 3) ? 10'h040 :
                  (longSeen ? 10'h100 : 10'h200);
        longSeen <= longSeen | $past(addrLong, 3);
      end
    end
  end
  a_dq_highz: assert property (dqOutEnN)
    else $error("data outputs driven");
  a_current_off: assert property (calCurrentOn == calBusy)
    else $error("calibration current outside window");
  a_enter_low: assert property ($rose(lowPower) |-> !$past(ckeIn, 3))
    else $error("low power entered without cke low");
  a_exit_low: assert property ($fell(lowPower) |-> $past(ckeIn, 3))
    else $error("low power left without cke high");
  a_cal_cmd: assert property ($rose(calBusy) |-> $past(ckeIn, 3)
    && $past({csN, rasN, casN, weN}, 3) == dpz_pkg::CMD_ZQ)
    else $error("calibration without command");
  a_init_window: assert property ($fell(calBusy) && expWin == 10'h200
    |-> busyCnt + 10'h004 >= expWin && busyCnt <= expWin + 10'h004)
    else $error("first long window wrong");
  a_oper_window: assert property ($fell(calBusy) && expWin == 10'h100
    |-> busyCnt + 10'h004 >= expWin && busyCnt <= expWin + 10'h004)
    else $error("later long window wrong");
  a_short_window: assert property ($fell(calBusy) && expWin == 10'h040
    |-> busyCnt + 10'h004 >= expWin && busyCnt <= expWin + 10'h004)
    else $error("short window wrong");
  a_code_at_end: assert property ($changed(driverCode) |-> $fell(calBusy))
    else $error("code changed mid window");
  a_short_conv: assert property ($fell(calBusy) && expWin == 10'h040
    |-> ##[0:2] driverCode == calTarget)
    else $error("short calibration did not converge");
  c_low: cover property ($fell(lowPower));
  c_long: cover property ($fell(calBusy) && expWin == 10'h100);
  c_short: cover property ($fell(calBusy) && expWin == 10'h040);
endmodule
bind dpz_seq dpz_seq_asserts #(.CODE_W(CODE_W)) chk (.sys_clk, .rst_n,
  .ckeIn, .csN, .rasN, .casN, .weN, .addrLong, .selfRefreshExit,
  .calTarget, .lowPower, .calBusy, .calCurrentOn, .dqOutEnN, .driverCode);

// file: tb/dpz_ctl_model.sv
// dpz_ctl_model: memory controller side, drives cke and command pins
// assumes: caller waits out every window before the next send
`timescale 1ns/1ps
module dpz_ctl_model (
  input  wire logic       sys_clk,
  output logic            cke,
  output logic [3:0]      cmd,
  output logic            lng
);
  // no termination pin is driven, so termination stays off
  initial begin
    cke = 1'b1;
    cmd = 4'hF;
    lng = 1'b0;
  end
  // deselected lines show inverted values, so stale data cannot pass
  task automatic send(input logic [3:0] c, input logic k, input logic l);
    @(posedge sys_clk);
    cke <= k;
    cmd <= c;
    lng <= l;
    @(posedge sys_clk);
    cmd <= {1'b1, ~c[2:0]};
    lng <= ~l;
  endtask
endmodule

// file: tb/dpz_seq_tb.sv
// dpz_seq_tb: power-down and calibration scenarios
// assumes: controller model and checker compiled alongside
`timescale 1ns/1ps
module dpz_seq_tb;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ckeIn;
  logic       addrLong;
  logic       selfRefreshExit = 1'b0;
  logic [3:0] cmd;
  logic [5:0] calTarget = 6'h00;
  logic       lowPower;
  logic       calBusy;
  logic [5:0] driverCode;
  int         errors = 0;
  int         n_checks = 0;
  always #5 sys_clk = ~sys_clk;
  dpz_ctl_model ctl (.sys_clk(sys_clk), .cke(ckeIn), .cmd(cmd), .lng(addrLong));
  dpz_seq uut (.sys_clk(sys_clk), .rst_n(rst_n), .ckeIn(ckeIn),
    .csN(cmd[3]), .rasN(cmd[2]), .casN(cmd[1]), .weN(cmd[0]),
    .addrLong(addrLong), .selfRefreshExit(selfRefreshExit),
    .calTarget(calTarget), .lowPower(lowPower), .calBusy(calBusy),
    .calCurrentOn(), .dqOutEnN(), .driverCode(driverCode));
  task automatic check(input string what, input logic [9:0] e,
                       input logic [9:0] g);
    #1;
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic t_cal(input logic l, input int win, input logic [5:0] t);
    int n;
    calTarget <= t;
    ctl.send(dpz_pkg::CMD_ZQ, 1'b1, l);
    n = 0;
    while (calBusy !== 1'b1 && n < 10) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    // one device only, so windows never overlap
    while (calBusy === 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    check("window", 10'h001, 10'(n + 4 >= win && n <= win + 4));
    repeat (3) @(posedge sys_clk);
    check("driverCode", 10'(t), 10'(driverCode));
  endtask
  task automatic t_power_down;
    ctl.send(dpz_pkg::CMD_REF, 1'b1, 1'b0);
    ctl.send(dpz_pkg::CMD_NOP, 1'b0, 1'b0);
    repeat (4) @(posedge sys_clk);
    check("lowPower", 10'h001, 10'(lowPower));
    ctl.send(dpz_pkg::CMD_ZQ, 1'b0, 1'b1);
    repeat (5) @(posedge sys_clk);
    check("calBusy", 10'h000, 10'(calBusy));
    ctl.send(dpz_pkg::CMD_NOP, 1'b1, 1'b0);
    repeat (4) @(posedge sys_clk);
    check("lowPower", 10'h000, 10'(lowPower));
  endtask
  task automatic t_self_refresh;
    selfRefreshExit <= 1'b1;
    repeat (6) @(posedge sys_clk);
    selfRefreshExit <= 1'b0;
    check("calBusy", 10'h000, 10'(calBusy));
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_cal(1'b1, 512, 6'h2A);
    t_cal(1'b1, 256, 6'h05);
    t_cal(1'b0, 64, 6'h15);
    t_power_down;
    t_self_refresh;
    t_cal(1'b1, 256, 6'h0C);
    end_of_test;
  end
endmodule
